// ### common/psv_pkg.sv
// Constants shared by the priority security view block
package psv_pkg;
  // Register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] PRIO_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] GROUP_OFF = 12'h080;
  localparam logic [ADDR_W-1:0] PMR_OFF = 12'h100;
  localparam logic [ADDR_W-1:0] RPR_OFF = 12'h104;
  localparam logic [ADDR_W-1:0] INFO_OFF = 12'h108;
  // Field layout
  localparam int DATA_W = 32;
  localparam int PRIO_W = 8;
  localparam int TOP_BIT = 7;
  localparam int LANES = 4;
  localparam int PPROT_NS_BIT = 1;
  // Reset values
  localparam logic [PRIO_W-1:0] PRIO_RESET = 8'h00;
  localparam logic [PRIO_W-1:0] PMR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] GROUP_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  // Access view selection
  typedef enum logic [1:0] {
    PSV_VIEW_SECURE = 2'b01,
    PSV_VIEW_NONSEC = 2'b10
  } psv_view_t;
endpackage

// ### hw/psv_priority_view.sv
// APB priority field store with Secure and Non-secure views
// Summary of operation
// [R1] Secure write may clear top bit, stored as is
// [R2] NS read of NS group 1 returns shifted bits
// [R3] NS write always leaves top bit set
// [R4] NS mask access zero and ignored if top clear
// [R5] NS running priority reads zero if top clear
// [R6] Secure step follows implemented bit count
// [R7] NS view has twice the Secure step
// [R8] NS sees nothing of Secure interrupt priorities
// [R9] All-ones write keeps only implemented bits
// [R10] Software disables interrupt before probing range
// [R11] Pending instance may use old or new
// [R12] Rewrite never duplicates or drops an interrupt
// [R13] Rewrite takes effect within bounded cycles
// [R14] Software gives group 0 top bit zero
// [R15] Secure writes of NS priority set top; the code stores a Secure write with only the implemented-bit mask applied
// [R16] Suggested top two bits allocation per group
// [R17] NS write shifts right and forces top bit
// [R18] Secure read returns the stored value exactly
// [R19] Five to eight upper bits implemented
// [R20] Implemented bit count is one shared parameter
// [R21] Security attribute sampled with each access
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module psv_priority_view
  import psv_pkg::*;
#(
  parameter int NUM_IRQ = 32,
  parameter int PRIO_BITS = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [LANES-1:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Running priority from the CPU interface
  input wire logic [PRIO_W-1:0] cpu_running_priority,
  // Stored state toward the prioritisation logic
  output logic [NUM_IRQ*PRIO_W-1:0] prio_out,
  output logic [NUM_IRQ-1:0] nsg1_out,
  output logic [PRIO_W-1:0] cpu_priority_mask
);

  // Implemented-bit mask used by store, priority mask and translation
  localparam logic [PRIO_W-1:0] IMPL_MASK = 8'(8'hFF << (PRIO_W - PRIO_BITS)); // [R20]
  localparam int WORDS = (NUM_IRQ + LANES - 1) / LANES;
  localparam logic [ADDR_W-1:0] PRIO_END = ADDR_W'(PRIO_BASE + WORDS * LANES);
  localparam logic [DATA_W-1:0] INFO_VALUE = DATA_W'(PRIO_BITS);

  // Storage
  logic [PRIO_W-1:0] prio_r [NUM_IRQ];
  logic [PRIO_W-1:0] rview [NUM_IRQ];
  logic [DATA_W-1:0] nsg1_r;
  logic [PRIO_W-1:0] pmr_r;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  // Access decode
  logic setup;
  logic wr_acc;
  logic ns_acc;
  logic in_prio;
  logic [ADDR_W-3:0] word_idx;
  psv_view_t view;

  // Non-secure view of a stored value: shift up, bit zero reads zero
  function automatic logic [PRIO_W-1:0] ns_read(input logic [PRIO_W-1:0] v);
    ns_read = {v[TOP_BIT-1:0], 1'b0}; // [R2] [R7]
  endfunction

  // Non-secure write translation into the upper half of the value range, top bit set
  function automatic logic [PRIO_W-1:0] ns_write(input logic [PRIO_W-1:0] v);
    ns_write = {1'b1, v[TOP_BIT:1]} & IMPL_MASK; // [R17] [R3]
  endfunction

  // Bus decode; security attribute rides with each transfer
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign ns_acc = pprot[PPROT_NS_BIT]; // [R21]
  assign view = ns_acc ? PSV_VIEW_NONSEC : PSV_VIEW_SECURE;
  assign in_prio = (paddr >= PRIO_BASE) && (paddr < PRIO_END);
  assign word_idx = paddr[ADDR_W-1:2] - PRIO_BASE[ADDR_W-1:2];
  assign pready = 1'b1;

  // Per-interrupt priority field and its read view
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
    localparam int LANE = i % LANES;
    localparam logic [ADDR_W-3:0] WIDX = (ADDR_W-2)'(i / LANES);
    logic hit;
    logic [PRIO_W-1:0] wbyte;
    assign hit = wr_acc && in_prio && (word_idx == WIDX) && pstrb[LANE];
    assign wbyte = pwdata[LANE*PRIO_W +: PRIO_W];

    // Field update; one word write replaces the value atomically
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prio_r[i] <= PRIO_RESET;
      end else if (hit) begin
        case (view)
          PSV_VIEW_SECURE: begin
            prio_r[i] <= wbyte & IMPL_MASK; // [R1] [R9] [R19]
          end
          PSV_VIEW_NONSEC: begin
            if (nsg1_r[i]) begin
              prio_r[i] <= ns_write(wbyte); // [R17] [R3] [R9]
            end
          end
          default: begin
            prio_r[i] <= prio_r[i];
          end
        endcase
      end
    end

    // Read view per security state
    always_comb begin
      if (!ns_acc) begin
        rview[i] = prio_r[i]; // [R18] [R6]
      end else if (nsg1_r[i]) begin
        rview[i] = ns_read(prio_r[i]); // [R2] [R7]
      end else begin
        rview[i] = PRIO_RESET & 8'h00; // [R8]
      end
    end

    // Stored value drives prioritisation the cycle after the write
    assign prio_out[i*PRIO_W +: PRIO_W] = prio_r[i]; // [R11] [R12] [R13]
    assign nsg1_out[i] = nsg1_r[i];
  end

  // Group register: Secure only, bit set marks Non-secure group 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nsg1_r <= GROUP_RESET;
    end else if (wr_acc && paddr == GROUP_OFF && !ns_acc) begin // [R8]
      for (int b = 0; b < LANES; b++) begin
        if (pstrb[b]) begin
          nsg1_r[b*PRIO_W +: PRIO_W] <= pwdata[b*PRIO_W +: PRIO_W];
        end
      end
    end
  end

  // Priority mask: Non-secure writes ignored while top bit clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmr_r <= PMR_RESET;
    end else if (wr_acc && paddr == PMR_OFF && pstrb[0]) begin
      if (!ns_acc) begin
        pmr_r <= pwdata[PRIO_W-1:0] & IMPL_MASK; // [R9]
      end else if (pmr_r[TOP_BIT]) begin
        pmr_r <= ns_write(pwdata[PRIO_W-1:0]); // [R4]
      end
    end
  end
  assign cpu_priority_mask = pmr_r;

  // Read data mux and unmapped-address error
  always_comb begin
    prdata_nxt = ZERO_WORD;
    pslverr_nxt = 1'b0;
    if (in_prio) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (word_idx == (ADDR_W-2)'(i / LANES)) begin
          prdata_nxt[(i % LANES)*PRIO_W +: PRIO_W] = rview[i];
        end
      end
    end else if (paddr == GROUP_OFF) begin
      prdata_nxt = ns_acc ? ZERO_WORD : nsg1_r; // [R8]
    end else if (paddr == PMR_OFF) begin
      if (!ns_acc) begin
        prdata_nxt[PRIO_W-1:0] = pmr_r;
      end else if (pmr_r[TOP_BIT]) begin
        prdata_nxt[PRIO_W-1:0] = ns_read(pmr_r); // [R4]
      end
    end else if (paddr == RPR_OFF) begin
      if (!ns_acc) begin
        prdata_nxt[PRIO_W-1:0] = cpu_running_priority;
      end else if (cpu_running_priority[TOP_BIT]) begin
        prdata_nxt[PRIO_W-1:0] = ns_read(cpu_running_priority); // [R5]
      end
    end else if (paddr == INFO_OFF) begin
      prdata_nxt = INFO_VALUE;
    end else begin
      pslverr_nxt = 1'b1;
    end
  end

  // Read data captured in the setup cycle, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= ZERO_WORD;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? ZERO_WORD : prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // Checks on field zero and the mask and running-priority views
  property p_sec_store;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && !ns_acc && in_prio && word_idx == '0 && pstrb[0])
      |=> prio_r[0] == ($past(pwdata[PRIO_W-1:0]) & IMPL_MASK);
  endproperty
  a_sec_store: assert property (p_sec_store) else $error("secure priority store wrong"); // [R1]

  property p_ns_store;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && ns_acc && nsg1_r[0] && in_prio && word_idx == '0 && pstrb[0])
      |=> prio_r[0][TOP_BIT] && prio_r[0] == ns_write($past(pwdata[PRIO_W-1:0]));
  endproperty
  a_ns_store: assert property (p_ns_store) else $error("ns priority translation wrong"); // [R17]

  property p_ns_view;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && ns_acc && nsg1_r[0] && in_prio && word_idx == '0)
      |=> prdata[PRIO_W-1:0] == {$past(prio_r[0][TOP_BIT-1:0]), 1'b0} && !prdata[0];
  endproperty
  a_ns_view: assert property (p_ns_view) else $error("ns priority view wrong"); // [R2]

  property p_sec_view;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && !ns_acc && in_prio && word_idx == '0)
      |=> prdata[PRIO_W-1:0] == $past(prio_r[0]);
  endproperty
  a_sec_view: assert property (p_sec_view) else $error("secure view not stored value"); // [R18]

  property p_ns_hidden;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && ns_acc && !nsg1_r[0] && in_prio && word_idx == '0)
      |=> $stable(prio_r[0]);
  endproperty
  a_ns_hidden: assert property (p_ns_hidden) else $error("ns wrote secure priority"); // [R8]

  property p_pmr_wi;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && ns_acc && paddr == PMR_OFF && !pmr_r[TOP_BIT]) |=> $stable(pmr_r);
  endproperty
  a_pmr_wi: assert property (p_pmr_wi) else $error("ns mask write not ignored"); // [R4]

  property p_rpr_raz;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && ns_acc && paddr == RPR_OFF && !cpu_running_priority[TOP_BIT])
      |=> prdata == ZERO_WORD;
  endproperty
  a_rpr_raz: assert property (p_rpr_raz) else $error("ns running priority visible"); // [R5]

  property p_impl_bits;
    @(posedge pclk) disable iff (!presetn)
      ((prio_r[0] & ~IMPL_MASK) == PRIO_RESET) && ((pmr_r & ~IMPL_MASK) == PMR_RESET);
  endproperty
  a_impl_bits: assert property (p_impl_bits) else $error("unimplemented bits set"); // [R19]

  property p_effect;
    @(posedge pclk) disable iff (!presetn)
      $changed(prio_r[0]) |-> prio_out[PRIO_W-1:0] == prio_r[0] && $past(wr_acc);
  endproperty
  a_effect: assert property (p_effect) else $error("priority change without write"); // [R13]

  // Further checks on steps, probes and hidden registers
  property p_ns_top_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && ns_acc && nsg1_r[1] && in_prio && word_idx == '0 && pstrb[1])
      |=> prio_r[1][TOP_BIT];
  endproperty
  a_ns_top_set: assert property (p_ns_top_set) else $error("ns top bit clear"); // [R3]

  property p_sec_step;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && !ns_acc && in_prio && word_idx == '0)
      |=> (prdata[PRIO_W-1:0] & ~IMPL_MASK) == PRIO_RESET;
  endproperty
  a_sec_step: assert property (p_sec_step) else $error("secure step wrong"); // [R6]

  property p_ns_step;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && ns_acc && nsg1_r[0] && in_prio && word_idx == '0)
      |=> (prdata[PRIO_W-1:0] & ~{IMPL_MASK[PRIO_W-2:0], 1'b0}) == PRIO_RESET;
  endproperty
  a_ns_step: assert property (p_ns_step) else $error("ns step wrong"); // [R7]

  property p_all_ones;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && !ns_acc && in_prio && word_idx == '0 && pstrb[0] && &pwdata[PRIO_W-1:0])
      |=> prio_r[0] == IMPL_MASK;
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("probe kept wrong bits"); // [R9]

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_acc && in_prio && word_idx == '0)
      |=> $stable(prio_out[PRIO_W-1:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("priority moved without write"); // [R12]

  property p_mask_raz;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && ns_acc && paddr == PMR_OFF && !pmr_r[TOP_BIT])
      |=> prdata == ZERO_WORD;
  endproperty
  a_mask_raz: assert property (p_mask_raz) else $error("ns mask visible"); // [R4]

  property p_run_view;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && ns_acc && paddr == RPR_OFF && cpu_running_priority[TOP_BIT])
      |=> prdata[PRIO_W-1:0] == {$past(cpu_running_priority[TOP_BIT-1:0]), 1'b0};
  endproperty
  a_run_view: assert property (p_run_view) else $error("ns running view wrong"); // [R5]

  property p_group_raz;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && ns_acc && paddr == GROUP_OFF)
      |=> prdata == ZERO_WORD;
  endproperty
  a_group_raz: assert property (p_group_raz) else $error("ns group visible"); // [R8]

  property p_group_wi;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && ns_acc && paddr == GROUP_OFF)
      |=> $stable(nsg1_r);
  endproperty
  a_group_wi: assert property (p_group_wi) else $error("ns group write taken"); // [R8]

  property p_info;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == INFO_OFF)
      |=> prdata == INFO_VALUE;
  endproperty
  a_info: assert property (p_info) else $error("bit count read wrong"); // [R20]

endmodule

// ### verification/psv_priority_view_tb_top.sv
// Testbench for the priority security view block
`timescale 1ns/1ps
module psv_priority_view_tb_top
  import psv_pkg::*;
;
  localparam int PB = 6;
  // Bus and side signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [LANES-1:0] pstrb;
  logic [2:0] pprot;
  logic [PRIO_W-1:0] run_prio, mask_q;
  logic [32*PRIO_W-1:0] prio_q;
  logic [31:0] nsg1_q;
  int err_total, checks_done, cyc;

  // Six implemented bits, so stored fields keep mask 0xFC
  psv_priority_view #(.NUM_IRQ(32), .PRIO_BITS(PB)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_running_priority(run_prio),
    .prio_out(prio_q), .nsg1_out(nsg1_q), .cpu_priority_mask(mask_q)
  );

  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Closing report
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Word comparison
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; ns picks the Non-secure view
  task automatic apb(input logic w, input logic ns, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare
  task automatic rchk(input logic ns, input logic [11:0] a, input logic [31:0] exp,
                      input string nm);
    apb(1'b0, ns, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // Test sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    pprot = 3'b000;
    run_prio = 8'h40;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(1'b0, PRIO_BASE, 32'h0000_0000, "prio reset");
    apb(1'b1, 1'b0, GROUP_OFF, 32'h0000_000F);
    rchk(1'b0, GROUP_OFF, 32'h0000_000F, "group");
    rchk(1'b1, GROUP_OFF, 32'h0000_0000, "group ns");
    apb(1'b1, 1'b1, GROUP_OFF, 32'hFFFF_FFFF);
    rchk(1'b0, GROUP_OFF, 32'h0000_000F, "group kept");
    chk("group port", 32'h0000_000F, nsg1_q);
    apb(1'b1, 1'b0, PRIO_BASE, 32'h7FFF_4001);
    #1 chk("prio_out", 32'h7CFC_4000, prio_q[31:0]);
    rchk(1'b0, PRIO_BASE, 32'h7CFC_4000, "prio sec");
    rchk(1'b1, PRIO_BASE, 32'hF8F8_8000, "prio ns");
    apb(1'b1, 1'b1, PRIO_BASE, 32'hFFFF_FF02);
    rchk(1'b0, PRIO_BASE, 32'hFCFC_FC80, "prio ns write");
    rchk(1'b1, PRIO_BASE, 32'hF8F8_F800, "prio ns view");
    pstrb <= 4'h2;
    apb(1'b1, 1'b0, PRIO_BASE, 32'h1111_3311);
    pstrb <= 4'hF;
    rchk(1'b0, PRIO_BASE, 32'hFCFC_3080, "prio strobe");
    apb(1'b1, 1'b0, PRIO_BASE + 12'h004, 32'h1122_3344);
    apb(1'b1, 1'b1, PRIO_BASE + 12'h004, 32'hFFFF_FFFF);
    rchk(1'b0, PRIO_BASE + 12'h004, 32'h1020_3044, "secure irq");
    rchk(1'b1, PRIO_BASE + 12'h004, 32'h0000_0000, "secure irq ns");
    apb(1'b1, 1'b0, PMR_OFF, 32'h0000_0040);
    rchk(1'b1, PMR_OFF, 32'h0000_0000, "mask ns low");
    apb(1'b1, 1'b1, PMR_OFF, 32'h0000_00FF);
    rchk(1'b0, PMR_OFF, 32'h0000_0040, "mask kept");
    chk("mask port", 32'h0000_0040, {24'h0, mask_q});
    apb(1'b1, 1'b0, PMR_OFF, 32'h0000_00C0);
    rchk(1'b1, PMR_OFF, 32'h0000_0080, "mask ns high");
    rchk(1'b1, RPR_OFF, 32'h0000_0000, "run ns low");
    rchk(1'b0, RPR_OFF, 32'h0000_0040, "run sec");
    run_prio <= 8'hA4;
    rchk(1'b1, RPR_OFF, 32'h0000_0048, "run ns high");
    rchk(1'b0, INFO_OFF, PB, "info");
    apb(1'b1, 1'b0, GROUP_OFF, 32'h0000_0C0F);
    apb(1'b1, 1'b0, PRIO_BASE + 12'h008, 32'hE0A0_6020);
    rchk(1'b0, PRIO_BASE + 12'h008, 32'hE0A0_6020, "alloc sec");
    chk("group port 2", 32'h0000_0C0F, nsg1_q);
    rchk(1'b1, PRIO_BASE + 12'h008, 32'hC040_0000, "alloc ns");
    apb(1'b1, 1'b0, PRIO_BASE, 32'hFFFF_FFFF);
    rchk(1'b0, PRIO_BASE, 32'hFCFC_FCFC, "probe sec");
    apb(1'b1, 1'b1, PRIO_BASE, 32'hFFFF_FFFF);
    rchk(1'b1, PRIO_BASE, 32'hF8F8_F8F8, "probe ns");
    apb(1'b1, 1'b0, 12'h200, 32'hFFFF_FFFF);
    chk("slverr write", 32'h1, {31'h0, err_q});
    rchk(1'b0, 12'h200, 32'h0000_0000, "unmapped");
    chk("slverr read", 32'h1, {31'h0, err_q});
    tally_and_finish();
  end
endmodule
